// [hdl/itw_pkg.sv]
/*
  Shared constants and types for the interval timer and watchdog block:
  register indices, field positions, reset values and prescaler counts.
  Assumes nothing of its surroundings; compiled before every design file.
*/
package itw_pkg;

  // apb address width and data width
  localparam int unsigned ITW_AW = 12;
  localparam int unsigned ITW_DW = 32;

  // register indices; byte address is four times the index
  localparam logic [9:0] ITW_IDX_BIT_CTRL = 10'h08B;
  localparam logic [9:0] ITW_IDX_BIT_CNT  = 10'h08C;
  localparam logic [9:0] ITW_IDX_WDT_CTRL = 10'h08D;
  localparam logic [9:0] ITW_IDX_WDT_CNT  = 10'h08E;

  // interval_timer_control field positions
  localparam int unsigned ITW_BC_IFR    = 7;
  localparam int unsigned ITW_BC_CK_HI  = 6;
  localparam int unsigned ITW_BC_CK_LO  = 5;
  localparam int unsigned ITW_BC_CLR    = 3;
  localparam int unsigned ITW_BC_TAP_HI = 2;
  localparam int unsigned ITW_BC_TAP_LO = 0;

  // watchdog_control field positions
  localparam int unsigned ITW_WC_RUN = 7;
  localparam int unsigned ITW_WC_RST = 6;
  localparam int unsigned ITW_WC_CLR = 5;
  localparam int unsigned ITW_WC_RC  = 1;
  localparam int unsigned ITW_WC_IFR = 0;

  // reset values
  localparam logic [7:0] ITW_BIT_CTRL_RST = 8'h01;
  localparam logic [7:0] ITW_BIT_CNT_RST  = 8'h00;
  localparam logic [7:0] ITW_WDT_CTRL_RST = 8'h00;
  localparam logic [7:0] ITW_WDT_CNT_RST  = 8'h00;
  localparam logic [7:0] ITW_WDT_CMP_RST  = 8'hFF;

  // prescaler: last count of each division (divide by value+1)
  localparam int unsigned ITW_PRE_W = 12;
  localparam logic [11:0] ITW_DIV4096_LAST = 12'hFFF;
  localparam logic [11:0] ITW_DIV1024_LAST = 12'h3FF;
  localparam logic [11:0] ITW_DIV128_LAST  = 12'h07F;
  localparam logic [11:0] ITW_DIV16_LAST   = 12'h00F;

  // interval overflows counted for the oscillator stabilisation wait
  localparam int unsigned ITW_STAB_OVF = 4;

  typedef struct packed {
    logic       ifr;
    logic [1:0] clkSel;
    logic       clr;
    logic [2:0] tap;
  } itw_bitctl_type;

  typedef struct packed {
    logic run;
    logic rstSel;
    logic clr;
    logic rcSel;
    logic ifr;
  } itw_wdtctl_type;

  localparam itw_bitctl_type ITW_BITCTL_INIT = '{
    ifr:    ITW_BIT_CTRL_RST[ITW_BC_IFR],
    clkSel: ITW_BIT_CTRL_RST[ITW_BC_CK_HI:ITW_BC_CK_LO],
    clr:    ITW_BIT_CTRL_RST[ITW_BC_CLR],
    tap:    ITW_BIT_CTRL_RST[ITW_BC_TAP_HI:ITW_BC_TAP_LO]
  };

  localparam itw_wdtctl_type ITW_WDTCTL_INIT = '{
    run:    ITW_WDT_CTRL_RST[ITW_WC_RUN],
    rstSel: ITW_WDT_CTRL_RST[ITW_WC_RST],
    clr:    ITW_WDT_CTRL_RST[ITW_WC_CLR],
    rcSel:  ITW_WDT_CTRL_RST[ITW_WC_RC],
    ifr:    ITW_WDT_CTRL_RST[ITW_WC_IFR]
  };

endpackage

// [hdl/itw_prescaler.sv]
/*
  Prescaler for the interval counter: a one-cycle enable pulse every
  4096, 1024, 128 or 16 system clocks, chosen by a two-bit select.
  Assumes select and restart come from logic on the same clock.
*/
module itw_prescaler
  import itw_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // control
  input  wire logic [1:0] clkSel,
  input  wire logic       restart,
  // enable pulse
  output logic            tick
);

  logic [ITW_PRE_W-1:0] cnt_r;
  logic [ITW_PRE_W-1:0] last;

  function automatic logic [ITW_PRE_W-1:0] lastCount(input logic [1:0] sel);
    case (sel)
      2'h0:    lastCount = ITW_DIV4096_LAST;
      2'h1:    lastCount = ITW_DIV1024_LAST;
      2'h2:    lastCount = ITW_DIV128_LAST;
      2'h3:    lastCount = ITW_DIV16_LAST;
      default: lastCount = ITW_DIV4096_LAST;
    endcase
  endfunction

  assign last = lastCount(clkSel);

  // a shorter select taking effect mid-count wraps at once (>=)
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (restart) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (cnt_r >= last) begin
      cnt_r <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      tick  <= 1'b0;
    end
  end

endmodule

// [hdl/itw_top.sv]
/*
  Interval timer with watchdog, registers reached over APB.
  Assumes: interrupt acknowledges and stop exit come from logic on
  ref_clk; the watchdog RC oscillator arrives as an asynchronous pin.
*/
// Chosen here: register access over APB.
// Notes on behaviour
// - interval counter free-runs, never stoppable
// - clear bit zeroes counter, self-clears next cycle
// - overflow sets interval flag; write-zero or ack clears
// - control resets 01H, counter resets 00H
// - interval timer times oscillator stabilisation waits
// - watchdog advances once per interval overflow, or once per RC oscillator rising edge when selected
// - watchdog flag raised when counter equals compare
// - bit 6 picks interrupt only or CPU reset
// - bit 5 zeroes watchdog counter, self-clears
// - match interval is tick period (interval overflow, or RC rising edge when selected) times (compare+1)
// - shared address: read counter, write compare
// - osc select picks overflow or RC oscillator
// - watchdog flag cleared by write-zero or ack
module itw_top
  import itw_pkg::*;
#(
  parameter int unsigned STAB_OVF = ITW_STAB_OVF
)
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ITW_AW-1:0] paddr,
  input  wire logic [ITW_DW-1:0] pwdata,
  output logic      [ITW_DW-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // interrupt controller
  input  wire logic              bitIntAck,
  input  wire logic              wdtIntAck,
  output logic                   bitIrq,
  output logic                   wdtIrq,
  // system control
  input  wire logic              stopExit,
  output logic                   oscStable,
  output logic                   cpuResetReq,
  // watchdog rc oscillator
  input  wire logic              wdtRcClk,
  output logic                   wdtRcEnable
);

  itw_bitctl_type bitCtl_r;
  itw_wdtctl_type wdtCtl_r;
  logic [7:0]     interval_count_value_r;
  logic [7:0]     watchdog_count_r;
  logic [7:0]     wdtCmp_r;
  logic           preTick;
  logic           bitOvf;
  logic           wdtTick;
  logic           wdtMatch;
  logic           setup;
  logic           access;
  logic           wrEn;
  logic           bitCtlWr;
  logic           wdtCtlWr;
  logic           wdtCmpWr;
  logic           mapped;
  logic [7:0]     rdValue;
  logic           rcMeta_r;
  logic           rcSync_r;
  logic           rcLast_r;
  logic           rcTick;
  logic [7:0]     stabCnt_r;

  function automatic logic regHit(input logic [ITW_AW-1:0] addr,
                                  input logic [9:0]        idx);
    regHit = (addr == {idx, 2'b00});
  endfunction

  function automatic logic [7:0] tapMask(input logic [2:0] tap);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      m[i] = (i <= int'(tap));
    end
    tapMask = m;
  endfunction

  // ---------------- apb slave: no wait states, ready in the first access cycle
  assign setup  = psel & ~penable;
  assign access = psel & penable & pready;
  assign wrEn   = access & pwrite & ~pslverr;

  assign mapped = regHit(paddr, ITW_IDX_BIT_CTRL) | regHit(paddr, ITW_IDX_BIT_CNT) |
                  regHit(paddr, ITW_IDX_WDT_CTRL) | regHit(paddr, ITW_IDX_WDT_CNT);

  assign bitCtlWr = wrEn & regHit(paddr, ITW_IDX_BIT_CTRL);
  assign wdtCtlWr = wrEn & regHit(paddr, ITW_IDX_WDT_CTRL);
  assign wdtCmpWr = wrEn & regHit(paddr, ITW_IDX_WDT_CNT);

  always_comb begin
    rdValue = 8'h00;
    if (regHit(paddr, ITW_IDX_BIT_CTRL)) begin
      rdValue = {bitCtl_r.ifr, bitCtl_r.clkSel, 1'b0, bitCtl_r.clr, bitCtl_r.tap};
    end else if (regHit(paddr, ITW_IDX_BIT_CNT)) begin
      rdValue = interval_count_value_r;
    end else if (regHit(paddr, ITW_IDX_WDT_CTRL)) begin
      rdValue = {wdtCtl_r.run, wdtCtl_r.rstSel, wdtCtl_r.clr, 3'h0,
                 wdtCtl_r.rcSel, wdtCtl_r.ifr};
    end else if (regHit(paddr, ITW_IDX_WDT_CNT)) begin
      rdValue = watchdog_count_r;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= ~mapped;
        prdata  <= {24'h000000, rdValue};
      end else if (access) begin
        pslverr <= 1'b0;
      end
    end
  end

  // ---------------- interval timer
  itw_prescaler u_prescaler (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .clkSel  (bitCtl_r.clkSel),
    .restart (bitCtl_r.clr),
    .tick    (preTick)
  );

  // overflow when every bit up to the tap is one as the count advances
  assign bitOvf = preTick & ~bitCtl_r.clr &
                  ((interval_count_value_r & tapMask(bitCtl_r.tap)) == tapMask(bitCtl_r.tap));

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      interval_count_value_r <= ITW_BIT_CNT_RST;
    end else if (bitCtl_r.clr) begin
      interval_count_value_r <= 8'h00;
    end else if (preTick) begin
      interval_count_value_r <= interval_count_value_r + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bitCtl_r.clkSel <= ITW_BITCTL_INIT.clkSel;
      bitCtl_r.tap    <= ITW_BITCTL_INIT.tap;
      bitCtl_r.clr    <= ITW_BITCTL_INIT.clr;
    end else if (bitCtlWr) begin
      bitCtl_r.clkSel <= pwdata[ITW_BC_CK_HI:ITW_BC_CK_LO];
      bitCtl_r.tap    <= pwdata[ITW_BC_TAP_HI:ITW_BC_TAP_LO];
      bitCtl_r.clr    <= pwdata[ITW_BC_CLR];
    end else begin
      bitCtl_r.clr <= 1'b0;
    end
  end

  // flag: a new overflow wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bitCtl_r.ifr <= ITW_BITCTL_INIT.ifr;
    end else begin
      bitCtl_r.ifr <= bitOvf |
                      (bitCtl_r.ifr & ~((bitCtlWr & ~pwdata[ITW_BC_IFR]) | bitIntAck));
    end
  end

  // ---------------- oscillator stabilisation wait
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      oscStable <= 1'b0;
      stabCnt_r <= 8'h00;
    end else if (stopExit) begin
      oscStable <= 1'b0;
      stabCnt_r <= 8'h00;
    end else if (!oscStable && bitOvf) begin
      if (stabCnt_r == 8'(STAB_OVF - 1)) begin
        oscStable <= 1'b1;
      end else begin
        stabCnt_r <= stabCnt_r + 8'h01;
      end
    end
  end

  // ---------------- watchdog rc oscillator: synchronise, then edge detect
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rcMeta_r <= 1'b0;
      rcSync_r <= 1'b0;
      rcLast_r <= 1'b0;
    end else begin
      rcMeta_r <= wdtRcClk;
      rcSync_r <= rcMeta_r;
      rcLast_r <= rcSync_r;
    end
  end

  assign rcTick = rcSync_r & ~rcLast_r;

  // ---------------- watchdog
  assign wdtTick  = wdtCtl_r.rcSel ? rcTick : bitOvf;
  assign wdtMatch = wdtCtl_r.run & wdtTick & ~wdtCtl_r.clr &
                    (watchdog_count_r == wdtCmp_r);

  // wrapping at the match gives compare+1 ticks per interval
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      watchdog_count_r <= ITW_WDT_CNT_RST;
    end else if (wdtCtl_r.clr) begin
      watchdog_count_r <= 8'h00;
    end else if (wdtMatch) begin
      watchdog_count_r <= 8'h00;
    end else if (wdtCtl_r.run && wdtTick) begin
      watchdog_count_r <= watchdog_count_r + 8'h01;
    end
  end

  // a zero compare would match on every tick; software avoids it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wdtCmp_r <= ITW_WDT_CMP_RST;
    end else if (wdtCmpWr) begin
      wdtCmp_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wdtCtl_r.run    <= ITW_WDTCTL_INIT.run;
      wdtCtl_r.rstSel <= ITW_WDTCTL_INIT.rstSel;
      wdtCtl_r.rcSel  <= ITW_WDTCTL_INIT.rcSel;
      wdtCtl_r.clr    <= ITW_WDTCTL_INIT.clr;
    end else if (wdtCtlWr) begin
      wdtCtl_r.run    <= pwdata[ITW_WC_RUN];
      wdtCtl_r.rstSel <= pwdata[ITW_WC_RST];
      wdtCtl_r.rcSel  <= pwdata[ITW_WC_RC];
      wdtCtl_r.clr    <= pwdata[ITW_WC_CLR];
    end else begin
      wdtCtl_r.clr <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wdtCtl_r.ifr <= ITW_WDTCTL_INIT.ifr;
    end else begin
      wdtCtl_r.ifr <= wdtMatch |
                      (wdtCtl_r.ifr & ~((wdtCtlWr & ~pwdata[ITW_WC_IFR]) | wdtIntAck));
    end
  end

  // ---------------- outputs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cpuResetReq <= 1'b0;
      wdtRcEnable <= 1'b0;
    end else begin
      cpuResetReq <= wdtMatch & wdtCtl_r.rstSel;
      wdtRcEnable <= wdtCtl_r.rcSel;
    end
  end

  assign bitIrq = bitCtl_r.ifr;
  assign wdtIrq = wdtCtl_r.ifr;

endmodule

// [tb/itw_top_asserts.sv]
/*
  Port assertions for the interval timer and watchdog block.
  Assumes it is bound to itw_top and sees only that module's ports.
*/
module itw_top_asserts
  import itw_pkg::*;
#(
  parameter int unsigned STAB_OVF = ITW_STAB_OVF
)
(
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              resetn,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ITW_AW-1:0] paddr,
  input wire logic [ITW_DW-1:0] pwdata,
  input wire logic [ITW_DW-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // interrupts and system
  input wire logic              bitIntAck,
  input wire logic              wdtIntAck,
  input wire logic              bitIrq,
  input wire logic              wdtIrq,
  input wire logic              stopExit,
  input wire logic              oscStable,
  input wire logic              cpuResetReq,
  input wire logic              wdtRcClk,
  input wire logic              wdtRcEnable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_ready_follows: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_rdata_narrow: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_err_unmapped: assert property (pready && !(paddr inside {12'h22C, 12'h230, 12'h234,
    12'h238}) |-> pslverr) else $error("unmapped access without error");
  a_bit_flag_hold: assert property (bitIrq && !bitIntAck && !psel |=> bitIrq)
    else $error("interval flag dropped by itself");
  a_wdt_flag_hold: assert property (wdtIrq && !wdtIntAck && !psel |=> wdtIrq)
    else $error("watchdog flag dropped by itself");
  a_rst_after_flag: assert property (cpuResetReq |-> wdtIrq)
    else $error("cpu reset without watchdog match");
  a_rst_pulse: assert property (cpuResetReq |=> !cpuResetReq)
    else $error("cpu reset request too long");
  a_osc_hold: assert property (oscStable && !stopExit |=> oscStable)
    else $error("oscillator stable fell without stop exit");
  a_rc_enable: assert property ($changed(wdtRcEnable) |-> $past(psel && penable && pwrite, 2))
    else $error("rc enable changed without a write");
endmodule

bind itw_top itw_top_asserts #(.STAB_OVF(STAB_OVF)) u_itw_top_asserts (
  .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .bitIntAck(bitIntAck), .wdtIntAck(wdtIntAck), .bitIrq(bitIrq), .wdtIrq(wdtIrq),
  .stopExit(stopExit), .oscStable(oscStable), .cpuResetReq(cpuResetReq),
  .wdtRcClk(wdtRcClk), .wdtRcEnable(wdtRcEnable));

// [tb/testbench.sv]
/*
  Self-checking bench for the interval timer and watchdog.
  Assumes itw_top with STAB_OVF set to 1; drives every input itself.
*/
module testbench
  import itw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic              ref_clk, resetn, psel, penable, pwrite, er;
  logic              bitIntAck, wdtIntAck, stopExit, wdtRcClk;
  logic [ITW_AW-1:0] paddr;
  logic [ITW_DW-1:0] pwdata, prdata, rd;
  logic              pready, pslverr, bitIrq, wdtIrq, oscStable, cpuResetReq, wdtRcEnable;
  int                err_total = 0;
  int                checked = 0;

  itw_top #(.STAB_OVF(1)) u_itw_top (
    .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bitIntAck(bitIntAck), .wdtIntAck(wdtIntAck), .bitIrq(bitIrq), .wdtIrq(wdtIrq),
    .stopExit(stopExit), .oscStable(oscStable), .cpuResetReq(cpuResetReq),
    .wdtRcClk(wdtRcClk), .wdtRcEnable(wdtRcEnable));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // rc oscillator: eight system clocks a period, edges off the rising clock edges
  initial begin
    wdtRcClk = 1'b0;
    forever #100 wdtRcClk = ~wdtRcClk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (err_total == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic waitf(input bit w, output time t);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (!(w ? wdtIrq : bitIrq) && n < 20000);
    t = $time;
    chk({31'h0, w ? wdtIrq : bitIrq}, 32'h1);
  endtask

  // period in clocks between two flag raises, acking in between
  task automatic measure(input bit w, input logic [11:0] a, input logic [7:0] v, input int ex);
    time t0, t1;
    apb(1'b1, a, {24'h0, v});
    waitf(w, t0);
    @(posedge ref_clk);
    if (w) wdtIntAck <= 1'b1;
    else bitIntAck <= 1'b1;
    @(posedge ref_clk);
    wdtIntAck <= 1'b0;
    bitIntAck <= 1'b0;
    #1;
    chk({31'h0, w ? wdtIrq : bitIrq}, 32'h0);
    waitf(w, t1);
    chk(32'((t1 - t0) / 25), 32'(ex));
  endtask

  task automatic t_reset();
    time t;
    chk({31'h0, oscStable}, 32'h0);
    apb(1'b0, 12'h22C, 32'h0);
    chk(rd, 32'h01);
    apb(1'b0, 12'h230, 32'h0);
    chk(rd, 32'h00);
    apb(1'b0, 12'h234, 32'h0);
    chk(rd, 32'h00);
    apb(1'b0, 12'h238, 32'h0);
    chk(rd, 32'h00);
    apb(1'b0, 12'h000, 32'h0);
    chk({31'h0, er}, 32'h1);
    waitf(1'b0, t);
    chk({31'h0, oscStable}, 32'h1);
  endtask

  task automatic t_interval();
    logic [31:0] c;
    apb(1'b1, 12'h22C, 32'h60);
    apb(1'b0, 12'h230, 32'h0);
    c = rd;
    repeat (157) @(posedge ref_clk);
    apb(1'b0, 12'h230, 32'h0);
    chk(rd, (c + 32'd10) & 32'hFF);
    for (int k = 0; k < 4; k++) begin
      measure(1'b0, 12'h22C, 8'h08 | 8'(k << 5),
              (k == 0 ? 4096 : k == 1 ? 1024 : k == 2 ? 128 : 16) * 2);
    end
    for (int k = 0; k < 8; k++) begin
      measure(1'b0, 12'h22C, 8'h68 | 8'(k), 16 << (k + 1));
    end
    apb(1'b0, 12'h22C, 32'h0);
    chk(rd & 32'h7F, 32'h67);
    @(posedge ref_clk);
    stopExit <= 1'b1;
    @(posedge ref_clk);
    stopExit <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk({31'h0, oscStable}, 32'h0);
    // tap 7 on the /16 clock overflows every 4096 cycles
    repeat (4200) @(posedge ref_clk);
    chk({31'h0, oscStable}, 32'h1);
  endtask

  task automatic t_watchdog();
    int n;
    apb(1'b1, 12'h22C, 32'h68);
    apb(1'b1, 12'h238, 32'h02);
    apb(1'b1, 12'h234, 32'h20);
    apb(1'b0, 12'h238, 32'h0);
    chk(rd, 32'h00);
    repeat (100) @(posedge ref_clk);
    apb(1'b0, 12'h238, 32'h0);
    chk(rd, 32'h00);
    apb(1'b0, 12'h234, 32'h0);
    chk(rd, 32'h00);
    measure(1'b1, 12'h234, 8'hA0, 96);
    apb(1'b1, 12'h234, 32'hC0);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (cpuResetReq !== 1'b1 && n < 200);
    chk({31'h0, cpuResetReq}, 32'h1);
    measure(1'b1, 12'h234, 8'h82, 24);
    chk({31'h0, wdtRcEnable}, 32'h1);
  endtask

  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    bitIntAck = 1'b0;
    wdtIntAck = 1'b0;
    stopExit = 1'b0;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset();
    t_interval();
    t_watchdog();
    results();
  end

  initial begin
    #(90000 * 25);
    err_total++;
    results();
  end
endmodule
